// *** rtl/fxu_div.sv ***
// Purpose: Sequential fractional divider, fifteen quotient bits.
// Assumes: Positive operands, divisor not below the dividend.
// Notes:   Quotient is held until the next start.
`timescale 1ns/10ps
module fxu_div
  import fxu_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Request.
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [31:0] divisor,
  // Answer.
  output logic             done,
  output logic [15:0]      quotient
);

  fxu_div_state_type st_reg;
  fxu_div_state_type st_next;

  // ----------------------------------------------------------------
  // Restoring division
  // ----------------------------------------------------------------
  // One quotient bit per cycle keeps the comparator narrow; an equal
  // pair yields all ones, the largest positive fraction.
  always_comb begin
    logic [32:0] twice;
    twice        = {st_reg.rem[31:0], 1'b0};
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (start) begin
      st_next.run   = 1'b1;
      st_next.sat   = dividend > divisor;
      st_next.steps = DIV_STEPS;
      st_next.rem   = {1'b0, dividend};
      st_next.den   = divisor;
      st_next.quo   = '0;
    end else if (st_reg.run) begin
      if (twice >= {1'b0, st_reg.den}) begin
        st_next.rem = twice - {1'b0, st_reg.den};
        st_next.quo = {st_reg.quo[13:0], 1'b1};
      end else begin
        st_next.rem = twice;
        st_next.quo = {st_reg.quo[13:0], 1'b0};
      end
      st_next.steps = st_reg.steps - 4'd1;
      if (st_reg.steps == 4'd1) begin
        st_next.run  = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= DIV_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // The answer is taken from the next state so that the caller can
  // register it at the finishing edge; the top then reports it without
  // adding a cycle of its own to the divide latency.
  assign done     = st_next.done;
  assign quotient = st_next.sat ? MAX16 : {1'b0, st_next.quo};

endmodule

// *** rtl/fxu_pkg.sv ***
// Purpose: Shared types and constants of the fixed-point operator unit.
// Assumes: One clock; results and flags travel as packed structs.
// Notes:   Sixteen-bit results are returned sign-extended to 32 bits.
package fxu_pkg;

  // ----------------------------------------------------------------
  // Numeric limits and constants
  // ----------------------------------------------------------------
  localparam logic [31:0] MAX32      = 32'h7fff_ffff;
  localparam logic [31:0] MIN32      = 32'h8000_0000;
  localparam logic [15:0] MAX16      = 16'h7fff;
  localparam logic [15:0] MIN16      = 16'h8000;
  localparam logic [31:0] ROUND_BIAS = 32'h0000_8000;
  localparam logic [31:0] MULT_EDGE  = 32'h4000_0000;
  localparam logic [3:0]  DIV_STEPS  = 4'hf;

  // ----------------------------------------------------------------
  // Operator codes
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_AND16, OP_OR16, OP_XOR16, OP_AND32, OP_OR32, OP_XOR32,
    OP_LOGIC_SHIFT_UP_16, OP_LOGIC_SHIFT_DOWN_16,
    OP_LOGIC_SHIFT_UP_32, OP_LOGIC_SHIFT_DOWN_32,
    OP_HIGH_HALF, OP_LOW_HALF, OP_ROUND_TO_UPPER_HALF,
    OP_DEPOSIT_HIGH, OP_DEPOSIT_LOW, OP_ADD_CARRY, OP_SUB_BORROW,
    OP_MAC_NONSATURATING, OP_MSUB_NONSATURATING,
    OP_RSHIFT_DOWN_16, OP_RSHIFT_UP_16, OP_RSHIFT_DOWN_32, OP_RSHIFT_UP_32,
    OP_INT_MULT, OP_ROT_UP_16, OP_ROT_DOWN_16, OP_ROT_UP_32, OP_ROT_DOWN_32,
    OP_SATURATE, OP_MIXED_MULT, OP_FRAC_DIV, OP_LONG_FRAC_DIV
  } fxu_op_type;

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    fxu_op_type  op;
    logic [31:0] opa;
    logic [31:0] opb;
  } fxu_req_type;

  typedef struct packed {
    logic [31:0] value;
    logic        bit_out;
  } fxu_res_type;

  typedef struct packed {
    logic carry;
    logic ovf;
  } fxu_flags_type;

  typedef struct packed {
    logic          res_valid;
    fxu_res_type   res;
    logic          busy;
    fxu_flags_type flags;
  } fxu_top_state_type;

  typedef struct packed {
    logic        run;
    logic        done;
    logic        sat;
    logic [3:0]  steps;
    logic [32:0] rem;
    logic [31:0] den;
    logic [14:0] quo;
  } fxu_div_state_type;

  localparam fxu_top_state_type TOP_RESET = '0;
  localparam fxu_div_state_type DIV_RESET = '0;

endpackage

// *** rtl/fxu_rshift.sv ***
// Purpose: Rounding arithmetic shift toward the bottom, any width.
// Assumes: Count is a signed 17-bit value so a negated count cannot wrap.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module fxu_rshift
  import fxu_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Operand and count.
  input  wire logic [WIDTH-1:0]  value,
  input  wire logic signed [16:0] count,
  // Rounded, saturated result.
  output logic      [WIDTH-1:0]  result
);

  localparam logic [WIDTH-1:0] MAXV = {1'b0, {(WIDTH-1){1'b1}}};
  localparam logic [WIDTH-1:0] MINV = {1'b1, {(WIDTH-1){1'b0}}};

  // ----------------------------------------------------------------
  // Shift logic
  // ----------------------------------------------------------------
  // A positive count shifts down with sign fill and adds the last bit
  // shifted out; the sum cannot overflow because a shifted value is
  // always below the maximum. Otherwise shift up and saturate.
  always_comb begin
    logic signed [WIDTH-1:0] sv;
    logic signed [WIDTH-1:0] dn;
    logic signed [WIDTH-1:0] last;
    logic signed [WIDTH-1:0] up;
    logic [16:0]             n;
    sv   = value;
    n    = count[16] ? 17'(-count) : 17'(count);
    dn   = sv >>> n;
    last = sv >>> (n - 17'd1);
    up   = sv <<< n;
    if (!count[16] && (count != 17'sd0)) begin
      result = dn + WIDTH'(last[0]);
    end else if ((up >>> n) != sv) begin
      result = sv[WIDTH-1] ? MINV : MAXV;
    end else begin
      result = up;
    end
  end

endmodule

// *** rtl/fxu_top.sv ***
// Purpose: Fixed-point operator unit: logic, shifts, conversion, carry
//          arithmetic, rounding shifts, multiplies and divides.
// Assumes: Operands are synchronous to clk; one request per cycle.
// Notes:   Overview of operation is listed below.
`timescale 1ns/10ps
module fxu_top
  import fxu_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          reset_n,
  // Request.
  input  wire logic          req_valid,
  input  wire fxu_req_type   req,
  // Flag write.
  input  wire logic          flag_wr,
  input  wire fxu_flags_type flag_wr_data,
  // Answer and status.
  output logic               res_valid,
  output fxu_res_type        res,
  output logic               busy,
  output fxu_flags_type      flags
);

  // ----------------------------------------------------------------
  // Operand views
  // ----------------------------------------------------------------
  fxu_top_state_type  st_reg;
  fxu_top_state_type  st_next;
  logic               accept;
  logic               is_div;
  logic signed [15:0] a16;
  logic signed [15:0] b16;
  logic signed [31:0] a32;
  logic signed [16:0] cnt;
  logic signed [16:0] rcnt;
  logic        [16:0] mag;
  logic signed [31:0] prod16;
  logic signed [47:0] prod48;
  logic signed [31:0] dbl;
  logic        [31:0] second;
  logic        [32:0] sum33;
  logic        [32:0] diff33;
  logic        [32:0] rnd33;
  logic        [15:0] rs16;
  logic        [31:0] rs32;
  logic               div_start;
  logic               div_done;
  logic        [15:0] div_q;
  logic        [31:0] div_den;

  // Operands are read as signed two's complement values.
  assign a16 = req.opa[15:0];
  assign b16 = req.opb[15:0];
  assign a32 = req.opa;
  assign cnt = {b16[15], b16};
  assign mag = cnt[16] ? 17'(-cnt) : 17'(cnt);

  // Requests are refused while a divide is running.
  assign accept    = req_valid && !st_reg.busy;
  assign is_div    = (req.op == OP_FRAC_DIV) || (req.op == OP_LONG_FRAC_DIV);
  assign div_start = accept && is_div;
  // The long divide compares against the divisor moved to the top half.
  assign div_den   = (req.op == OP_LONG_FRAC_DIV) ? {req.opb[15:0], 16'h0000} : req.opb;

  // ----------------------------------------------------------------
  // Arithmetic feeds
  // ----------------------------------------------------------------
  // The up-shifting rounding forms reuse the down shifter with the
  // count negated; 17 bits keep the most negative count exact.
  assign rcnt = ((req.op == OP_RSHIFT_UP_16) || (req.op == OP_RSHIFT_UP_32)) ? -cnt : cnt;

  // Products: the doubled product saturates only for two minimums.
  assign prod16 = a16 * b16;
  assign prod48 = a32 * b16;
  assign dbl    = ($signed(req.opb[31:16]) * b16 == MULT_EDGE) ? MAX32 :
                  32'($signed(req.opb[31:16]) * b16 * 2);

  // One adder and one subtractor serve both carry ops and the
  // accumulate forms, which take the doubled product as addend.
  assign second = ((req.op == OP_MAC_NONSATURATING) || (req.op == OP_MSUB_NONSATURATING)) ? dbl : req.opb;
  assign sum33  = {1'b0, req.opa} + {1'b0, second} + {32'h0000_0000, st_reg.flags.carry};
  assign diff33 = {1'b0, req.opa} - {1'b0, second} - {32'h0000_0000, st_reg.flags.carry};
  assign rnd33  = {a32[31], req.opa} + {1'b0, ROUND_BIAS};

  // Rounding shifters.
  fxu_rshift #(.WIDTH(16)) u_rs16 (
    .value  (req.opa[15:0]),
    .count  (rcnt),
    .result (rs16)
  );

  fxu_rshift #(.WIDTH(32)) u_rs32 (
    .value  (req.opa),
    .count  (rcnt),
    .result (rs32)
  );

  // Divider.
  fxu_div u_div (
    .clk      (clk),
    .reset_n  (reset_n),
    .start    (div_start),
    .dividend (req.opa),
    .divisor  (div_den),
    .done     (div_done),
    .quotient (div_q)
  );

  // Sign extension of a sixteen-bit result.
  function automatic logic [31:0] sx16(input logic [15:0] v);
    sx16 = {{16{v[15]}}, v};
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // A flag write is applied first so that a carry op accepted in the
  // same cycle overrides it; the op's outcome is the newer fact.
  always_comb begin
    st_next           = st_reg;
    st_next.res_valid = 1'b0;
    if (flag_wr) begin
      st_next.flags = flag_wr_data;
    end
    if (div_done) begin
      st_next.res.value   = sx16(div_q);
      st_next.res.bit_out = 1'b0;
      st_next.res_valid   = 1'b1;
      st_next.busy        = 1'b0;
    end
    if (accept) begin
      st_next.res_valid   = !is_div;
      st_next.busy        = is_div;
      st_next.res.bit_out = 1'b0;
      unique case (req.op)
        OP_AND16:  st_next.res.value = sx16(a16 & b16);
        OP_OR16:   st_next.res.value = sx16(a16 | b16);
        OP_XOR16:  st_next.res.value = sx16(a16 ^ b16);
        OP_AND32:  st_next.res.value = req.opa & req.opb;
        OP_OR32:   st_next.res.value = req.opa | req.opb;
        OP_XOR32:  st_next.res.value = req.opa ^ req.opb;
        OP_LOGIC_SHIFT_UP_16:
          st_next.res.value = sx16(cnt[16] ? 16'(a16 >> mag) : 16'(a16 << mag));
        OP_LOGIC_SHIFT_DOWN_16:
          st_next.res.value = sx16(cnt[16] ? 16'(a16 << mag) : 16'(a16 >> mag));
        OP_LOGIC_SHIFT_UP_32:
          st_next.res.value = cnt[16] ? req.opa >> mag : req.opa << mag;
        OP_LOGIC_SHIFT_DOWN_32:
          st_next.res.value = cnt[16] ? req.opa << mag : req.opa >> mag;
        OP_HIGH_HALF: st_next.res.value = sx16(req.opa[31:16]);
        OP_LOW_HALF:  st_next.res.value = sx16(req.opa[15:0]);
        OP_ROUND_TO_UPPER_HALF:
          st_next.res.value = sx16((!a32[31] && rnd33[31]) ? MAX16 : rnd33[31:16]);
        OP_DEPOSIT_HIGH: st_next.res.value = {req.opa[15:0], 16'h0000};
        OP_DEPOSIT_LOW:  st_next.res.value = sx16(req.opa[15:0]);
        OP_ADD_CARRY, OP_MAC_NONSATURATING: begin
          st_next.res.value = sum33[31:0];
          st_next.flags.carry = sum33[32];
          st_next.flags.ovf = (req.opa[31] == second[31]) && (sum33[31] != req.opa[31]);
        end
        OP_SUB_BORROW, OP_MSUB_NONSATURATING: begin
          st_next.res.value = diff33[31:0];
          st_next.flags.carry = diff33[32];
          st_next.flags.ovf = (req.opa[31] != second[31]) && (diff33[31] != req.opa[31]);
        end
        OP_RSHIFT_DOWN_16, OP_RSHIFT_UP_16: st_next.res.value = sx16(rs16);
        OP_RSHIFT_DOWN_32, OP_RSHIFT_UP_32: st_next.res.value = rs32;
        OP_INT_MULT:
          st_next.res.value = sx16((prod16 > 32'sh0000_7fff) ? MAX16 :
                                   (prod16 < -32'sh0000_8000) ? MIN16 : prod16[15:0]);
        OP_ROT_UP_16: begin
          st_next.res.value   = sx16({req.opa[14:0], req.opb[0]});
          st_next.res.bit_out = req.opa[15];
        end
        OP_ROT_DOWN_16: begin
          st_next.res.value   = sx16({req.opb[0], req.opa[15:1]});
          st_next.res.bit_out = req.opa[0];
        end
        OP_ROT_UP_32: begin
          st_next.res.value   = {req.opa[30:0], req.opb[0]};
          st_next.res.bit_out = req.opa[31];
        end
        OP_ROT_DOWN_32: begin
          st_next.res.value   = {req.opb[0], req.opa[31:1]};
          st_next.res.bit_out = req.opa[0];
        end
        OP_SATURATE:
          st_next.res.value = !st_reg.flags.ovf ? req.opa :
                              (st_reg.flags.carry ? MIN32 : MAX32);
        OP_MIXED_MULT:
          st_next.res.value = (prod48[47] != prod48[46]) ? (prod48[47] ? MIN32 : MAX32) :
                              prod48[46:15];
        OP_FRAC_DIV, OP_LONG_FRAC_DIV: st_next.res.bit_out = 1'b0;
        default: st_next.res.value = 32'h0000_0000;
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= TOP_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign res_valid = st_reg.res_valid;
  assign res       = st_reg.res;
  assign busy      = st_reg.busy;
  assign flags     = st_reg.flags;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Delayed copies of the accepted request for the checks below.
  fxu_req_type   req_q;
  fxu_flags_type flags_q;
  logic          acc_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_q   <= '0;
      flags_q <= '0;
      acc_q   <= 1'b0;
    end else begin
      req_q   <= req;
      flags_q <= st_reg.flags;
      acc_q   <= accept;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_div_go;
    accept && is_div;
  endsequence

  sequence s_div_wait;
    busy && !res_valid ##14 busy && !res_valid;
  endsequence

  property p_and16;
    acc_q && req_q.op == OP_AND16 |-> res_valid && res.value[15:0] == (req_q.opa[15:0] & req_q.opb[15:0]);
  endproperty
  a_and16: assert property (p_and16) else $error("16-bit AND wrong");

  property p_xor32;
    acc_q && req_q.op == OP_XOR32 |-> res.value == (req_q.opa ^ req_q.opb);
  endproperty
  a_xor32: assert property (p_xor32) else $error("32-bit XOR wrong");

  property p_shift_up;
    acc_q && req_q.op == OP_LOGIC_SHIFT_UP_16 && req_q.opb[15:4] == 12'h000
      |-> res.value[15:0] == 16'(req_q.opa[15:0] << req_q.opb[3:0]);
  endproperty
  a_shift_up: assert property (p_shift_up) else $error("logic shift up wrong");

  property p_high_half;
    acc_q && req_q.op == OP_HIGH_HALF |-> res.value[15:0] == req_q.opa[31:16];
  endproperty
  a_high_half: assert property (p_high_half) else $error("high half wrong");

  property p_deposit_low;
    acc_q && req_q.op == OP_DEPOSIT_LOW |-> res.value == {{16{req_q.opa[15]}}, req_q.opa[15:0]};
  endproperty
  a_deposit_low: assert property (p_deposit_low) else $error("low deposit wrong");

  property p_add_carry;
    acc_q && req_q.op == OP_ADD_CARRY
      |-> {flags.carry, res.value} == {1'b0, req_q.opa} + {1'b0, req_q.opb} + {32'h0000_0000, flags_q.carry};
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add with carry wrong");

  property p_rot_up;
    acc_q && req_q.op == OP_ROT_UP_16
      |-> res.bit_out == req_q.opa[15] && res.value[15:0] == {req_q.opa[14:0], req_q.opb[0]};
  endproperty
  a_rot_up: assert property (p_rot_up) else $error("rotate up wrong");

  property p_saturate;
    acc_q && req_q.op == OP_SATURATE && flags_q.ovf |-> res.value == (flags_q.carry ? MIN32 : MAX32);
  endproperty
  a_saturate: assert property (p_saturate) else $error("saturate wrong");

  property p_latency;
    accept && !is_div |=> res_valid && !busy;
  endproperty
  a_latency: assert property (p_latency) else $error("result not one cycle later");

  property p_div;
    s_div_go |=> s_div_wait ##1 res_valid && !busy;
  endproperty
  a_div: assert property (p_div) else $error("divide timing wrong");

endmodule

// *** tb/fxu_cpu_model.sv ***
// Purpose: Pipeline stand-in that issues queued requests and flag writes.
// Assumes: Items are pushed by the bench; one item per cycle at most.
// Notes:   Idle operands are inverted each cycle so stale values never look valid.
`timescale 1ns/10ps
module fxu_cpu_model
  import fxu_pkg::*;
(
  // Clock and status.
  input  wire logic     clk,
  input  wire logic     busy,
  // Request side.
  output logic          req_valid,
  output fxu_req_type   req,
  output logic          flag_wr,
  output fxu_flags_type flag_wr_data
);
  typedef struct packed {
    logic          rude;
    logic          fw;
    fxu_flags_type fd;
    fxu_req_type   rq;
  } fxu_item_type;

  fxu_item_type q[$];
  fxu_item_type it;
  int           t_q[$];
  int           cyc = 0;

  // Cycle count used by the bench to time each answer.
  always @(posedge clk) begin
    cyc++;
  end

  // Issue on the falling edge; a rude item ignores busy to provoke a refusal.
  always @(negedge clk) begin
    if (q.size() > 0 && (busy === 1'b0 || q[0].rude)) begin
      it = q.pop_front();
      req_valid <= ~it.fw;
      flag_wr <= it.fw;
      req <= it.rq;
      flag_wr_data <= it.fd;
      if (!it.fw && !it.rude) t_q.push_back(cyc);
    end else begin
      req_valid <= 1'b0;
      flag_wr <= 1'b0;
      req <= ~req;
      flag_wr_data <= ~flag_wr_data;
    end
  end

  // Known values at time zero.
  initial begin
    req_valid = 1'b0;
    flag_wr = 1'b0;
    req = '0;
    flag_wr_data = '0;
  end
endmodule

// *** tb/test_fixed_point_logic_shift_div_unit.sv ***
// Purpose: Self-checking bench comparing the unit with an integer model.
// Assumes: Requests and flag writes pass through the pipeline stand-in in order.
// Notes:   Model flags advance when an item is queued, matching issue order.
`timescale 1ns/10ps
module test_fixed_point_logic_shift_div_unit
  import fxu_pkg::*;
;
  typedef struct packed {
    fxu_res_type   r;
    fxu_flags_type f;
    logic          rot;
    logic [4:0]    lat;
  } fxu_exp_type;

  logic          clk;
  logic          reset_n;
  logic          req_valid;
  fxu_req_type   req;
  logic          flag_wr;
  fxu_flags_type flag_wr_data;
  logic          res_valid;
  fxu_res_type   res;
  logic          busy;
  fxu_flags_type flags;
  fxu_exp_type   eq[$];
  fxu_exp_type   ex;
  fxu_flags_type mf = '0;
  logic [31:0]   seed = 32'ha748_cc18;
  logic [31:0]   a, b, k;
  int            o;
  int            err_count = 0;
  int            num_checks = 0;

  fxu_top uut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req), .flag_wr(flag_wr),
    .flag_wr_data(flag_wr_data), .res_valid(res_valid), .res(res), .busy(busy), .flags(flags));
  fxu_cpu_model ptr (.clk(clk), .busy(busy), .req_valid(req_valid), .req(req), .flag_wr(flag_wr),
    .flag_wr_data(flag_wr_data));

  // ----------------------------------------------------------------
  // Model
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic longint sat(longint v, int w);
    longint hi;
    hi = (longint'(1) <<< (w - 1)) - 1;
    if (v > hi) return hi;
    if (v < -hi - 1) return -hi - 1;
    return v;
  endfunction

  function automatic logic [31:0] x16(logic [31:0] v);
    return {{16{v[15]}}, v[15:0]};
  endfunction

  function automatic logic [31:0] lsh(logic [31:0] v, int c, int w);
    logic [31:0] m;
    m = (w == 16) ? 32'h0000_ffff : 32'hffff_ffff;
    if (c >= w || c <= -w) return 32'h0000_0000;
    return c >= 0 ? (v << c) & m : (v & m) >> -c;
  endfunction

  // Rounding shift down; a non-positive count shifts up with saturation.
  function automatic longint rsh(longint v, int c, int w);
    if (c <= 0) return sat(v <<< -c, w);
    return sat((v >>> c) + ((v >>> (c - 1)) & 1), w);
  endfunction

  function automatic fxu_res_type calc(fxu_op_type op, logic [31:0] a, logic [31:0] b);
    longint sa, sb, h, l, s, u;
    int c;
    logic [31:0] bb;
    logic ad;
    sa = signed'(a);
    sb = signed'(b);
    h = signed'(a[15:0]);
    l = signed'(b[15:0]);
    c = signed'(b[15:0]);
    calc = '0;
    case (op)
      OP_AND16: calc.value = x16(a & b);
      OP_OR16: calc.value = x16(a | b);
      OP_XOR16: calc.value = x16(a ^ b);
      OP_AND32: calc.value = a & b;
      OP_OR32: calc.value = a | b;
      OP_XOR32: calc.value = a ^ b;
      OP_LOGIC_SHIFT_UP_16: calc.value = x16(lsh(a, c, 16));
      OP_LOGIC_SHIFT_DOWN_16: calc.value = x16(lsh(a, -c, 16));
      OP_LOGIC_SHIFT_UP_32: calc.value = lsh(a, c, 32);
      OP_LOGIC_SHIFT_DOWN_32: calc.value = lsh(a, -c, 32);
      OP_HIGH_HALF: calc.value = x16(a >> 16);
      OP_LOW_HALF, OP_DEPOSIT_LOW: calc.value = x16(a);
      OP_ROUND_TO_UPPER_HALF: calc.value = x16(32'(sat(sa + 32768, 32)) >> 16);
      OP_DEPOSIT_HIGH: calc.value = {a[15:0], 16'h0000};
      OP_ADD_CARRY, OP_SUB_BORROW, OP_MAC_NONSATURATING, OP_MSUB_NONSATURATING: begin
        // Accumulate forms add or take away the doubled, saturated product of the halves of b.
        bb = op inside {OP_ADD_CARRY, OP_SUB_BORROW} ? b : 32'(sat(2 * signed'(b[31:16]) * l, 32));
        ad = op inside {OP_ADD_CARRY, OP_MAC_NONSATURATING};
        sb = signed'(bb);
        s = ad ? sa + sb + mf.carry : sa - sb - mf.carry;
        u = ad ? longint'(a) + longint'(bb) + mf.carry : longint'(a) - longint'(bb) - mf.carry;
        mf.carry = ad ? u[32] : u < 0;
        mf.ovf = s != sat(s, 32);
        calc.value = 32'(s);
      end
      OP_RSHIFT_DOWN_16: calc.value = x16(32'(rsh(h, c, 16)));
      OP_RSHIFT_UP_16: calc.value = x16(32'(rsh(h, -c, 16)));
      OP_RSHIFT_DOWN_32: calc.value = 32'(rsh(sa, c, 32));
      OP_RSHIFT_UP_32: calc.value = 32'(rsh(sa, -c, 32));
      OP_INT_MULT: calc.value = x16(32'(sat(h * l, 16)));
      OP_ROT_UP_16: calc = {x16({a[14:0], b[0]}), a[15]};
      OP_ROT_DOWN_16: calc = {x16({b[0], a[15:1]}), a[0]};
      OP_ROT_UP_32: calc = {a[30:0], b[0], a[31]};
      OP_ROT_DOWN_32: calc = {b[0], a[31:1], a[0]};
      OP_SATURATE: calc.value = mf.ovf ? (mf.carry ? MIN32 : MAX32) : a;
      OP_MIXED_MULT: calc.value = 32'(sat((sa * l) >>> 15, 32));
      OP_FRAC_DIV, OP_LONG_FRAC_DIV: begin
        s = op == OP_FRAC_DIV ? h * 32768 / l : sa * 32768 / (l * 65536);
        calc.value = 32'(s > 32767 ? 32767 : s);
      end
      default: calc.value = 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Stimulus and checking
  // ----------------------------------------------------------------
  task automatic put(fxu_op_type op, logic [31:0] a, logic [31:0] b, logic rude = 1'b0);
    fxu_exp_type e;
    ptr.q.push_back({rude, 1'b0, 2'b00, op, a, b});
    if (!rude) begin
      e.r = calc(op, a, b);
      e.f = mf;
      e.rot = op inside {[OP_ROT_UP_16:OP_ROT_DOWN_32]};
      e.lat = op inside {OP_FRAC_DIV, OP_LONG_FRAC_DIV} ? 5'd16 : 5'd1;
      eq.push_back(e);
    end
  endtask

  task automatic wflag(fxu_flags_type f);
    ptr.q.push_back({1'b0, 1'b1, f, 70'h0});
    mf = f;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(logic got, logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Every answer is matched in order against the model, latency included.
  always @(negedge clk) begin
    if (res_valid === 1'b1) begin
      ex = eq.pop_front();
      chk(res.value, ex.r.value);
      if (ex.rot) chk_bit(res.bit_out, ex.r.bit_out);
      chk({30'h0, flags}, {30'h0, ex.f});
      chk(ptr.cyc - ptr.t_q.pop_front(), ex.lat);
    end
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cut a hang short well beyond the expected run of about five hundred cycles.
  initial begin
    #40000;
    err_count++;
    end_sim();
  end

  initial begin
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    chk({res_valid, busy, flags}, 32'h0000_0000);
    // Back-to-back random operators with boundary operands and flag writes mixed in.
    for (int i = 0; i < 300; i++) begin
      o = rnd() % 30;
      a = rnd();
      b = rnd();
      k = rnd();
      if (k[31]) a = k[30] ? MAX32 - k % 4 : MIN32 + k % 4;
      if (o inside {[6:9]}) b = 32'(int'(k % 80) - 40);
      if (o inside {[19:22]}) b = 32'(int'(k % 20) - 4);
      if (o == 20 || o == 22) b = -b;
      if (k[29:27] == 3'h0) wflag(fxu_flags_type'(k[1:0]));
      put(fxu_op_type'(o), a, b);
    end
    // Equal operands, then a request while busy that must be dropped.
    put(OP_FRAC_DIV, 32'h0000_04d2, 32'h0000_04d2);
    put(OP_ADD_CARRY, MAX32, MAX32, 1'b1);
    for (int i = 0; i < 10; i++) begin
      k = rnd() % 32'h0000_7fff + 1;
      if (i % 2) put(OP_FRAC_DIV, k, k + rnd() % (32'h0000_8000 - k));
      else put(OP_LONG_FRAC_DIV, rnd() % (k << 16) + 1, k);
    end
    put(OP_SATURATE, 32'h0000_0005, 32'h0000_0000);
    for (int t = 0; t < 2000 && eq.size() > 0; t++) @(negedge clk);
    repeat (3) @(negedge clk);
    chk(eq.size(), 0);
    end_sim();
  end
endmodule
